// [include/rmv_pkg.sv]
// Purpose: Shared constants and carrier types for the reference monitor and validation block.
// Assumes: One system clock; four reference inputs; 8-bit register port.
// Notes: Every address and width, the control register reset value and the tick figures live here.
// How it works
// - Monitors report fault until the system clock stability timer has expired.
// - Each reference has its own monitor repeatedly measuring and comparing its period.
// - Nominal period is an unsigned forty-bit femtosecond value.
// - Tolerances are twenty-bit reciprocals; larger value means tighter window.
// - A faulted reference clears only when deviation lies within inner tolerance.
// - A good reference faults only when deviation exceeds outer tolerance.
// - Sixteen-bit millisecond validation timer; reference must stay fault free throughout.
// - Zero validation period disables timer; host validates with force timeout.
// - Sixteen-bit millisecond redetect timer; stay faulted that long before reassignment.
// - Zero redetect period disables the redetect timer entirely.
// - Faulted high holds the valid latch reset and valid low.
// - With all override and bypass bits zero, faulted equals the monitor fault.
// - Rising faulted resets the validation timer, forcing a full recount.
// - Validation timer counts only while faulted is low, else reset and halted.
// - On validation expiry the valid latch loads the inverse of faulted.
// - Bypass set makes faulted follow the override bit, ignoring the monitor.
// - Bypass clear: override one forces faulted, zero follows monitor fault.
// - Writing one to force timeout triggers the valid latch, then self-clears.
package rmv_pkg;

    localparam int NUM_REFS = 4;
    localparam int PERIOD_W = 40;
    localparam int TOL_W = 20;
    localparam int TIMER_W = 16;
    localparam int SYSPER_W = 24;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register addresses of the override controls.
    localparam logic [ADDR_W-1:0] ADDR_FORCE_TIMEOUT = 16'h0a0e;
    localparam logic [ADDR_W-1:0] ADDR_MON_OVERRIDE = 16'h0a0f;
    localparam logic [ADDR_W-1:0] ADDR_MON_BYPASS = 16'h0a10;
    localparam logic [NUM_REFS-1:0] CTRL_RESET = 4'h0;

    // Millisecond time base: one tick per millisecond, counted in femtoseconds.
    localparam longint TICK_MS = 1;
    localparam longint FS_PER_MS = 64'd1000000000000;
    localparam logic [PERIOD_W:0] TICK_FS = (PERIOD_W+1)'(TICK_MS * FS_PER_MS);

    // Per-reference profile parameters handed over by the profile assignment logic.
    typedef struct packed {
        logic [PERIOD_W-1:0] nominal_fs;
        logic [TOL_W-1:0] inner_recip;
        logic [TOL_W-1:0] outer_recip;
        logic [TIMER_W-1:0] valid_ms;
        logic [TIMER_W-1:0] redetect_ms;
    } rmv_prof_t;

    // Register write/read request from the serial port decoder.
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rmv_reg_req_t;

endpackage : rmv_pkg

// [rtl/rmv_period_monitor.sv]
// Purpose: Period monitor for one reference input with hysteretic fault decision.
// Assumes: ref_in is asynchronous; sysclk_period_fs is the programmed clock period.
// Notes: A missing edge faults once elapsed time passes twice the nominal period.
`timescale 1ns/1ps
module rmv_period_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ref_in,
    input wire logic sysclk_stable,
    input wire logic [rmv_pkg::SYSPER_W-1:0] sysclk_period_fs,
    input wire rmv_pkg::rmv_prof_t prof,
    output logic ref_fault
);
    logic [2:0] sync_reg;
    logic level_reg;
    logic rise;
    logic [rmv_pkg::PERIOD_W:0] elapsed_reg;
    logic [rmv_pkg::PERIOD_W:0] dev;
    logic [rmv_pkg::PERIOD_W+rmv_pkg::TOL_W:0] dev_inner;
    logic [rmv_pkg::PERIOD_W+rmv_pkg::TOL_W:0] dev_outer;
    logic [rmv_pkg::PERIOD_W+rmv_pkg::TOL_W:0] nom_wide;
    logic [rmv_pkg::PERIOD_W+1:0] limit;
    logic fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_reg <= 3'h0;
            level_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], ref_in};
            if (sync_reg[1] == sync_reg[2]) begin
                level_reg <= sync_reg[2];
            end
        end
    end

    assign rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Elapsed time since the last rising edge, accumulated in femtoseconds.
    always_ff @(posedge clk) begin
        if (sys_rst || rise) begin
            elapsed_reg <= {{(rmv_pkg::PERIOD_W-rmv_pkg::SYSPER_W+1){1'b0}}, sysclk_period_fs};
        end else if (!elapsed_reg[rmv_pkg::PERIOD_W]) begin
            elapsed_reg <= elapsed_reg + {{(rmv_pkg::PERIOD_W-rmv_pkg::SYSPER_W+1){1'b0}},
                                          sysclk_period_fs};
        end
    end

    // Absolute deviation scaled by the reciprocal tolerances.
    always_comb begin
        dev = (elapsed_reg > {1'b0, prof.nominal_fs}) ? elapsed_reg - {1'b0, prof.nominal_fs}
                                                      : {1'b0, prof.nominal_fs} - elapsed_reg;
        // Both factors are widened to the full product width first, because a
        // self-sized product would wrap for large deviations or tight tolerances.
        dev_inner = {{rmv_pkg::TOL_W{1'b0}}, dev}
                    * {{(rmv_pkg::PERIOD_W+1){1'b0}}, prof.inner_recip};
        dev_outer = {{rmv_pkg::TOL_W{1'b0}}, dev}
                    * {{(rmv_pkg::PERIOD_W+1){1'b0}}, prof.outer_recip};
        nom_wide = {{(rmv_pkg::TOL_W+1){1'b0}}, prof.nominal_fs};
        limit = {1'b0, prof.nominal_fs, 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hysteretic decision: inner window to recover, outer window to fail.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_reg <= 1'b1;
        end else if (!sysclk_stable) begin
            fault_reg <= 1'b1;
        end else if (rise) begin
            if (fault_reg) begin
                fault_reg <= !(dev_inner <= nom_wide);
            end else begin
                fault_reg <= dev_outer > nom_wide;
            end
        end else if ({1'b0, elapsed_reg} > limit) begin
            fault_reg <= 1'b1; // Lost reference: no edge for twice the nominal period.
        end
    end

    assign ref_fault = fault_reg;

endmodule : rmv_period_monitor

// [rtl/rmv_ref_validation.sv]
// Purpose: Reference monitors, validation and redetect timers and override registers.
// Assumes: Register requests arrive one per cycle from the serial port decoder.
// Notes: Inner tolerance must be tighter than outer; the block does not check it.
`timescale 1ns/1ps
module rmv_ref_validation (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [rmv_pkg::NUM_REFS-1:0] ref_in,
    input wire logic sysclk_stable,
    input wire logic [rmv_pkg::SYSPER_W-1:0] sysclk_period_fs,
    input wire rmv_pkg::rmv_prof_t [rmv_pkg::NUM_REFS-1:0] prof,
    input wire logic [rmv_pkg::NUM_REFS-1:0] auto_select,
    input wire rmv_pkg::rmv_reg_req_t reg_req,
    output logic [rmv_pkg::DATA_W-1:0] rd_data,
    output logic [rmv_pkg::NUM_REFS-1:0] ref_valid,
    output logic [rmv_pkg::NUM_REFS-1:0] ref_faulted,
    output logic [rmv_pkg::NUM_REFS-1:0] redetect_pulse
);
    logic [rmv_pkg::NUM_REFS-1:0] force_reg;
    logic [rmv_pkg::NUM_REFS-1:0] override_reg;
    logic [rmv_pkg::NUM_REFS-1:0] bypass_reg;
    logic [rmv_pkg::DATA_W-1:0] rd_data_reg;
    logic [rmv_pkg::PERIOD_W:0] tick_acc_reg;
    logic ms_tick_reg;
    logic [rmv_pkg::NUM_REFS-1:0] mon_fault;
    logic [rmv_pkg::NUM_REFS-1:0] faulted;
    logic [rmv_pkg::NUM_REFS-1:0] faulted_reg;
    logic [rmv_pkg::NUM_REFS-1:0] valid_reg;
    logic [rmv_pkg::NUM_REFS-1:0] redet_reg;
    logic [rmv_pkg::NUM_REFS-1:0] expire;
    logic wr_force;
    logic wr_override;
    logic wr_bypass;

    assign wr_force = reg_req.wr_en && (reg_req.addr == rmv_pkg::ADDR_FORCE_TIMEOUT);
    assign wr_override = reg_req.wr_en && (reg_req.addr == rmv_pkg::ADDR_MON_OVERRIDE);
    assign wr_bypass = reg_req.wr_en && (reg_req.addr == rmv_pkg::ADDR_MON_BYPASS);

    ////////////////////////////////////////////////////////////////////////////
    // Force timeout bits self-clear the cycle after they are written with one.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_reg <= rmv_pkg::CTRL_RESET;
        end else if (wr_force) begin
            force_reg <= reg_req.wdata[rmv_pkg::NUM_REFS-1:0];
        end else begin
            force_reg <= rmv_pkg::CTRL_RESET;
        end
    end

    // Override and bypass bits hold whatever software last wrote.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            override_reg <= rmv_pkg::CTRL_RESET;
            bypass_reg <= rmv_pkg::CTRL_RESET;
        end else begin
            if (wr_override) begin
                override_reg <= reg_req.wdata[rmv_pkg::NUM_REFS-1:0];
            end
            if (wr_bypass) begin
                bypass_reg <= reg_req.wdata[rmv_pkg::NUM_REFS-1:0];
            end
        end
    end

    // Read data is registered; force timeout always reads back zero once cleared.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_reg <= 8'h00;
        end else if (reg_req.rd_en) begin
            case (reg_req.addr)
                rmv_pkg::ADDR_FORCE_TIMEOUT: rd_data_reg <= {4'h0, force_reg};
                rmv_pkg::ADDR_MON_OVERRIDE: rd_data_reg <= {4'h0, override_reg};
                rmv_pkg::ADDR_MON_BYPASS: rd_data_reg <= {4'h0, bypass_reg};
                default: rd_data_reg <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick: accumulate the programmed clock period until a full
    // millisecond has passed, keeping the remainder so no time drifts away.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_acc_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else if (tick_acc_reg >= rmv_pkg::TICK_FS) begin
            tick_acc_reg <= tick_acc_reg + {{(rmv_pkg::PERIOD_W-rmv_pkg::SYSPER_W+1){1'b0}},
                                            sysclk_period_fs} - rmv_pkg::TICK_FS;
            ms_tick_reg <= 1'b1;
        end else begin
            tick_acc_reg <= tick_acc_reg + {{(rmv_pkg::PERIOD_W-rmv_pkg::SYSPER_W+1){1'b0}},
                                            sysclk_period_fs};
            ms_tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One monitor, validation timer, valid latch and redetect timer per reference.
    generate
        for (genvar i = 0; i < rmv_pkg::NUM_REFS; i++) begin : g_ref
            logic [rmv_pkg::TIMER_W-1:0] val_cnt_reg;
            logic [rmv_pkg::TIMER_W-1:0] redet_cnt_reg;

            rmv_period_monitor u_mon (
                .clk(clk),
                .sys_rst(sys_rst),
                .ref_in(ref_in[i]),
                .sysclk_stable(sysclk_stable),
                .sysclk_period_fs(sysclk_period_fs),
                .prof(prof[i]),
                .ref_fault(mon_fault[i])
            );

            // Bypass hands the decision to the override bit; otherwise the
            // override bit can only add a fault on top of the monitor.
            assign faulted[i] = bypass_reg[i] ? override_reg[i]
                                              : (override_reg[i] | mon_fault[i]);

            // Timer stops at its terminal count so expiry fires only once.
            assign expire[i] = (prof[i].valid_ms != 16'h0000) && ms_tick_reg
                               && (val_cnt_reg == prof[i].valid_ms - 16'h0001);

            // Validation timer: reset and halted while faulted, so a new fault
            // always forces a full recount.
            always_ff @(posedge clk) begin
                if (sys_rst || faulted[i]) begin
                    val_cnt_reg <= 16'h0000;
                end else if (ms_tick_reg && (prof[i].valid_ms != 16'h0000)
                             && (val_cnt_reg != prof[i].valid_ms)) begin
                    val_cnt_reg <= val_cnt_reg + 16'h0001;
                end
            end

            // Valid latch: faulted clears it regardless of anything else.
            always_ff @(posedge clk) begin
                if (sys_rst || faulted[i]) begin
                    valid_reg[i] <= 1'b0;
                end else if (expire[i] || force_reg[i]) begin
                    valid_reg[i] <= !faulted[i];
                end
            end

            // Redetect timer counts while faulted; only automatic selection acts.
            always_ff @(posedge clk) begin
                if (sys_rst || !faulted[i] || (prof[i].redetect_ms == 16'h0000)) begin
                    redet_cnt_reg <= 16'h0000;
                    redet_reg[i] <= 1'b0;
                end else if (ms_tick_reg) begin
                    if (redet_cnt_reg == prof[i].redetect_ms - 16'h0001) begin
                        redet_cnt_reg <= 16'h0000;
                        redet_reg[i] <= auto_select[i];
                    end else begin
                        redet_cnt_reg <= redet_cnt_reg + 16'h0001;
                        redet_reg[i] <= 1'b0;
                    end
                end else begin
                    redet_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Registered copy of faulted so outputs come straight from flip-flops.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faulted_reg <= {rmv_pkg::NUM_REFS{1'b1}};
        end else begin
            faulted_reg <= faulted;
        end
    end

    assign rd_data = rd_data_reg;
    assign ref_valid = valid_reg;
    assign ref_faulted = faulted_reg;
    assign redetect_pulse = redet_reg;

endmodule : rmv_ref_validation

// [verification/rmv_ref_src.sv]
// Purpose: Model of the external reference sources feeding the block.
// Assumes: Half periods are given in ns and may change at any time.
// Notes: Edges are free running and unrelated to the system clock.
`timescale 1ns/1ps
module rmv_ref_src (
    input wire logic [3:0] run,
    input var int half_ns [4],
    output logic [3:0] ref_out
);
    for (genvar g = 0; g < 4; g++) begin : g_src
        logic lvl = 1'b0;
        // A stopped source drives its line low until run changes.
        always begin
            if (run[g]) begin
                #(half_ns[g]);
                lvl = ~lvl;
            end else begin
                lvl = 1'b0;
                @(run[g]);
            end
        end
        assign ref_out[g] = lvl;
    end
endmodule : rmv_ref_src

// [verification/rmv_ref_validation_props.sv]
// Purpose: Concurrent checks on faulted, valid, redetect and register behaviour.
// Assumes: Override and bypass registers are shadowed from the requests seen.
// Notes: Bound to the top module; one set of checks per reference.
`timescale 1ns/1ps
module rmv_ref_validation_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [rmv_pkg::NUM_REFS-1:0] ref_in,
    input wire logic sysclk_stable,
    input wire logic [rmv_pkg::SYSPER_W-1:0] sysclk_period_fs,
    input wire rmv_pkg::rmv_prof_t [rmv_pkg::NUM_REFS-1:0] prof,
    input wire logic [rmv_pkg::NUM_REFS-1:0] auto_select,
    input wire rmv_pkg::rmv_reg_req_t reg_req,
    input wire logic [rmv_pkg::DATA_W-1:0] rd_data,
    input wire logic [rmv_pkg::NUM_REFS-1:0] ref_valid,
    input wire logic [rmv_pkg::NUM_REFS-1:0] ref_faulted,
    input wire logic [rmv_pkg::NUM_REFS-1:0] redetect_pulse
);
    logic [3:0] byp_reg;
    logic [3:0] ovr_reg;
    logic [3:0] frc_vec;
    logic wr_frc;
    logic rd_frc;
    logic rd_ovr;
    logic rd_bad;
    ////////////////////////////////////////
    // Decodes stay combinational so the properties read plainly.
    assign wr_frc = reg_req.wr_en && reg_req.addr == rmv_pkg::ADDR_FORCE_TIMEOUT;
    assign rd_frc = reg_req.rd_en && reg_req.addr == rmv_pkg::ADDR_FORCE_TIMEOUT;
    assign rd_ovr = reg_req.rd_en && reg_req.addr == rmv_pkg::ADDR_MON_OVERRIDE;
    assign rd_bad = reg_req.rd_en && !rd_frc && !rd_ovr
        && reg_req.addr != rmv_pkg::ADDR_MON_BYPASS;
    assign frc_vec = wr_frc ? reg_req.wdata[3:0] : 4'h0;
    // Shadows tell the checks which source should steer faulted.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byp_reg <= 4'h0;
            ovr_reg <= 4'h0;
        end else if (reg_req.wr_en && reg_req.addr == rmv_pkg::ADDR_MON_BYPASS) begin
            byp_reg <= reg_req.wdata[3:0];
        end else if (reg_req.wr_en && reg_req.addr == rmv_pkg::ADDR_MON_OVERRIDE) begin
            ovr_reg <= reg_req.wdata[3:0];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
        ref_faulted == 4'hf && ref_valid == 4'h0 && rd_data == 8'h00)
        else $error("outputs wrong after reset");
    a_ovr_readback: assert property (rd_ovr |=> rd_data == {4'h0, $past(ovr_reg)})
        else $error("override readback wrong");
    a_force_selfclr: assert property (rd_frc && !$past(wr_frc) |=> rd_data == 8'h00)
        else $error("force bit did not clear");
    a_unmapped_zero: assert property (rd_bad |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    for (genvar g = 0; g < 4; g++) begin : g_ref
        sequence s_force_clean;
            frc_vec[g] ##2 !ref_faulted[g];
        endsequence
        a_fault_kills: assert property (ref_faulted[g] |-> !ref_valid[g])
            else $error("valid high while faulted");
        a_unstable_faults: assert property ((!sysclk_stable && !byp_reg[g])[*4] |-> ref_faulted[g])
            else $error("fault cleared before clock stable");
        a_override_faults: assert property (ovr_reg[g][*2] |-> ref_faulted[g])
            else $error("override did not fault");
        a_bypass_follow: assert property ((byp_reg[g] && !ovr_reg[g])[*2] |-> !ref_faulted[g])
            else $error("bypass did not follow override");
        a_force_loads: assert property (s_force_clean |-> ref_valid[g])
            else $error("force did not load valid");
        a_valid_cause: assert property ($rose(ref_valid[g]) |->
            prof[g].valid_ms != 16'h0000 || $past(frc_vec[g], 2))
            else $error("valid rose without timer or force");
        a_redetect_gate: assert property (redetect_pulse[g] |->
            auto_select[g] && prof[g].redetect_ms != 16'h0000 ##1 !redetect_pulse[g])
            else $error("redetect pulse not allowed");
    end
endmodule : rmv_ref_validation_props

bind rmv_ref_validation rmv_ref_validation_props u_props (.clk(clk), .sys_rst(sys_rst),
    .ref_in(ref_in), .sysclk_stable(sysclk_stable), .sysclk_period_fs(sysclk_period_fs),
    .prof(prof), .auto_select(auto_select), .reg_req(reg_req), .rd_data(rd_data),
    .ref_valid(ref_valid), .ref_faulted(ref_faulted), .redetect_pulse(redetect_pulse));

// [verification/rmv_ref_validation_tb.sv]
// Purpose: Self-checking bench for the reference monitor and validation block.
// Assumes: A large programmed clock period shortens the millisecond tick.
// Notes: Reference 1 is bypassed, reference 2 monitored, references 0 and 3 idle.
`timescale 1ns/1ps
module rmv_ref_validation_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sysclk_stable = 1'b0;
    logic [3:0] src_run = 4'h4;
    logic [3:0] ref_in;
    logic [3:0] pulse_seen = 4'h0;
    int half_ns [4] = '{500, 500, 500, 500};
    rmv_pkg::rmv_prof_t [3:0] prof;
    rmv_pkg::rmv_reg_req_t reg_req = '0;
    logic [7:0] rd_data;
    logic [3:0] ref_valid;
    logic [3:0] ref_faulted;
    logic [3:0] redetect_pulse;
    int num_errors = 0;
    int cmp_count = 0;
    ////////////////////////////////////////
    // Clock, and a sticky record of redetect pulses between checks.
    always #5 clk = ~clk;
    always @(posedge clk) pulse_seen <= pulse_seen | redetect_pulse;
    rmv_ref_src src (.run(src_run), .half_ns(half_ns), .ref_out(ref_in));
    rmv_ref_validation uut (.clk(clk), .sys_rst(sys_rst), .ref_in(ref_in),
        .sysclk_stable(sysclk_stable), .sysclk_period_fs(24'hffffff), .prof(prof),
        .auto_select(4'h9), .reg_req(reg_req), .rd_data(rd_data), .ref_valid(ref_valid),
        .ref_faulted(ref_faulted), .redetect_pulse(redetect_pulse));
    ////////////////////////////////////////
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp1
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        step(1);
        reg_req = '{1'b1, 1'b0, a, d};
        step(1);
        reg_req = '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        step(1);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        reg_req = '0;
        cmp8(rd_data, exp);
    endtask : reg_rd
    // A wait that runs out shows as a failed compare and ends the run.
    task automatic wait_bit(input bit sel, input int i, input logic e, input int bound);
        int n;
        for (n = 0; n < bound; n++) begin
            if ((sel ? ref_valid[i] : ref_faulted[i]) === e) break;
            step(1);
        end
        cmp1(sel ? ref_valid[i] : ref_faulted[i], e);
        if (n == bound) final_report();
    endtask : wait_bit
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4; i++) begin
            prof[i].nominal_fs = 40'h0063ffff9c;
            prof[i].inner_recip = 20'h00032;
            prof[i].outer_recip = 20'h0000a;
            prof[i].valid_ms = (i % 2 == 1) ? 16'h0001 : 16'h0000;
            prof[i].redetect_ms = (i == 0) ? 16'h0000 : 16'h0001;
        end
        step(3);
        sys_rst = 1'b0;
        cmp8({4'h0, ref_faulted}, 8'h0f);
        reg_rd(16'h0a11, 8'h00);
        step(1500);
        cmp1(ref_faulted[2], 1'b1);
        sysclk_stable = 1'b1;
        wait_bit(1'b0, 2, 1'b0, 3000);
        half_ns[2] = 525;
        step(1500);
        cmp1(ref_faulted[2], 1'b0);
        half_ns[2] = 650;
        wait_bit(1'b0, 2, 1'b1, 3000);
        half_ns[2] = 525;
        step(1500);
        cmp1(ref_faulted[2], 1'b1);
        half_ns[2] = 500;
        wait_bit(1'b0, 2, 1'b0, 3000);
        reg_wr(16'h0a0f, 8'hf4);
        step(2);
        cmp1(ref_faulted[2], 1'b1);
        reg_rd(16'h0a0f, 8'h04);
        reg_wr(16'h0a0f, 8'h00);
        step(2);
        cmp1(ref_faulted[2], 1'b0);
        reg_wr(16'h0a10, 8'h02);
        reg_rd(16'h0a10, 8'h02);
        cmp1(ref_faulted[1], 1'b0);
        reg_wr(16'h0a0f, 8'h02);
        step(2);
        cmp1(ref_faulted[1], 1'b1);
        reg_wr(16'h0a0f, 8'h00);
        wait_bit(1'b1, 1, 1'b1, 62000);
        step(2);
        cmp8({4'h0, pulse_seen}, 8'h08);
        cmp1(ref_valid[2], 1'b0);
        reg_wr(16'h0a0e, 8'h05);
        step(1);
        cmp1(ref_valid[2], 1'b1);
        cmp1(ref_valid[0], 1'b0);
        reg_rd(16'h0a0e, 8'h00);
        reg_wr(16'h0a0f, 8'h02);
        step(1);
        cmp1(ref_valid[1], 1'b0);
        reg_wr(16'h0a0f, 8'h00);
        step(2000);
        cmp1(ref_valid[1], 1'b0);
        final_report();
    end
endmodule : rmv_ref_validation_tb
